/* File: design/prio_regs_pkg.sv */
// package: register map, field layout and reset values of the low priority registers
package prio_regs_pkg;
  localparam int NUM_REGS = 6;
  localparam int NUM_SRC = 18;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  localparam int FIELD_HI = 12;
  localparam int FIELD_MID = 8;
  localparam int FIELD_LO = 4;
  localparam int FIELD_LOW0 = 0;
  localparam logic [11:0] OFFS_CTRL_0 = 12'h000;
  localparam logic [11:0] OFFS_CTRL_1 = 12'h004;
  localparam logic [11:0] OFFS_CTRL_2 = 12'h008;
  localparam logic [11:0] OFFS_CTRL_3 = 12'h00C;
  localparam logic [11:0] OFFS_CTRL_4 = 12'h010;
  localparam logic [11:0] OFFS_CTRL_5 = 12'h014;
  // implemented-bit masks per register
  localparam logic [15:0] MASK_CTRL_0 = 16'h7777;
  localparam logic [15:0] MASK_CTRL_1 = 16'h7770;
  localparam logic [15:0] MASK_CTRL_2 = 16'h7777;
  localparam logic [15:0] MASK_CTRL_3 = 16'h0077;
  localparam logic [15:0] MASK_CTRL_4 = 16'h7777;
  localparam logic [15:0] MASK_CTRL_5 = 16'h0007;
  localparam logic [15:0] RESET_CTRL_0 = 16'h4444;
  localparam logic [15:0] RESET_CTRL_1 = 16'h4440;
  localparam logic [15:0] RESET_CTRL_2 = 16'h4444;
  localparam logic [15:0] RESET_CTRL_3 = 16'h0044;
  localparam logic [15:0] RESET_CTRL_4 = 16'h4444;
  localparam logic [15:0] RESET_CTRL_5 = 16'h0004;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef logic [2:0] prio_t;

  // per-source priority bundle handed to the arbiter
  typedef struct packed {
    prio_t timer_one_prio;
    prio_t compare_one_prio;
    prio_t capture_one_prio;
    prio_t ext_irq_zero_prio;
    prio_t timer_two_prio;
    prio_t compare_two_prio;
    prio_t capture_two_prio;
    prio_t serial_one_rx_prio;
    prio_t spi_one_event_prio;
    prio_t spi_one_fault_prio;
    prio_t timer_three_prio;
    prio_t conversion_done_prio;
    prio_t serial_one_tx_prio;
    prio_t change_notify_prio;
    prio_t comparator_prio;
    prio_t i2c_one_master_prio;
    prio_t i2c_one_slave_prio;
    prio_t ext_irq_one_prio;
  } prio_bundle_t;
endpackage : prio_regs_pkg

/* File: design/interrupt_priority_regs_low.sv */
// module: AHB-Lite slave holding the low interrupt priority registers
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_regs_low (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output prio_regs_pkg::prio_bundle_t PRIO,
  output logic [prio_regs_pkg::NUM_SRC-1:0] SRC_ENABLED
);
  import prio_regs_pkg::*;

  logic [15:0] regs [NUM_REGS];
  logic wr_pend;
  logic [2:0] wr_idx;
  logic [2:0] addr_idx;
  logic addr_hit;
  logic take;
  logic [15:0] next_rdata;
  logic [15:0] masks [NUM_REGS];
  logic [15:0] resets [NUM_REGS];
  prio_bundle_t next_prio;
  logic [3*NUM_SRC-1:0] flat;

  assign masks[0] = MASK_CTRL_0;
  assign masks[1] = MASK_CTRL_1;
  assign masks[2] = MASK_CTRL_2;
  assign masks[3] = MASK_CTRL_3;
  assign masks[4] = MASK_CTRL_4;
  assign masks[5] = MASK_CTRL_5;
  assign resets[0] = RESET_CTRL_0;
  assign resets[1] = RESET_CTRL_1;
  assign resets[2] = RESET_CTRL_2;
  assign resets[3] = RESET_CTRL_3;
  assign resets[4] = RESET_CTRL_4;
  assign resets[5] = RESET_CTRL_5;

  // word-aligned decode; offsets beyond the six words are unmapped
  assign take = HSEL && HREADY && HTRANS[1];
  assign addr_idx = HADDR[4:2];
  assign addr_hit = (HADDR[11:5] == 7'h00) && (addr_idx < 3'(NUM_REGS));

  // address phase captured, write lands in the data phase
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      wr_pend <= 1'b0;
      wr_idx <= 3'h0;
    end else begin
      wr_pend <= take && HWRITE && addr_hit;
      wr_idx <= addr_idx;
    end
  end

  // unimplemented bits are masked on write so they can never hold a one
  always_ff @(posedge SYS_CLK) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (!RST_N) begin
        regs[i] <= resets[i];
      end else if (wr_pend && (wr_idx == 3'(i))) begin
        regs[i] <= HWDATA[15:0] & masks[i];
      end
    end
  end

  // read data registered at the address phase, so it stands in the data phase
  always_comb begin
    next_rdata = 16'h0000;
    if (addr_hit) begin
      next_rdata = regs[addr_idx] & masks[addr_idx];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (take && !HWRITE) begin
      HRDATA <= {16'h0000, next_rdata};
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      HREADYOUT <= 1'b0;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // field placement per register
  always_comb begin
    next_prio.timer_one_prio = regs[0][FIELD_HI +: 3];
    next_prio.compare_one_prio = regs[0][FIELD_MID +: 3];
    next_prio.capture_one_prio = regs[0][FIELD_LO +: 3];
    next_prio.ext_irq_zero_prio = regs[0][FIELD_LOW0 +: 3];
    next_prio.timer_two_prio = regs[1][FIELD_HI +: 3];
    next_prio.compare_two_prio = regs[1][FIELD_MID +: 3];
    next_prio.capture_two_prio = regs[1][FIELD_LO +: 3];
    next_prio.serial_one_rx_prio = regs[2][FIELD_HI +: 3];
    next_prio.spi_one_event_prio = regs[2][FIELD_MID +: 3];
    next_prio.spi_one_fault_prio = regs[2][FIELD_LO +: 3];
    next_prio.timer_three_prio = regs[2][FIELD_LOW0 +: 3];
    next_prio.conversion_done_prio = regs[3][FIELD_LO +: 3];
    next_prio.serial_one_tx_prio = regs[3][FIELD_LOW0 +: 3];
    next_prio.change_notify_prio = regs[4][FIELD_HI +: 3];
    next_prio.comparator_prio = regs[4][FIELD_MID +: 3];
    next_prio.i2c_one_master_prio = regs[4][FIELD_LO +: 3];
    next_prio.i2c_one_slave_prio = regs[4][FIELD_LOW0 +: 3];
    next_prio.ext_irq_one_prio = regs[5][FIELD_LOW0 +: 3];
  end

  assign flat = next_prio;

  // level equals code (7 highest, 1 lowest); outputs lag the register by one edge
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      PRIO <= {NUM_SRC{PRIO_RESET}};
    end else begin
      PRIO <= next_prio;
    end
  end

  // code zero means the source may never request
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_en
      always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
          SRC_ENABLED[g] <= 1'b1;
        end else begin
          SRC_ENABLED[g] <= (flat[3*g +: 3] != PRIO_OFF);
        end
      end
    end
  endgenerate

  // checks
  logic seen_rst;
  always_ff @(posedge SYS_CLK) begin
    seen_rst <= !RST_N ? 1'b1 : seen_rst;
  end

  rsv_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    HREADYOUT |-> (HRDATA[31:16] == 16'h0000))
    else $error("upper read bits not zero");
  reg3_gap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (regs[3] & ~MASK_CTRL_3) == 16'h0000)
    else $error("register 3 holds unimplemented bits");
  reg5_gap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    regs[5][15:3] == 13'h0000)
    else $error("register 5 holds unimplemented bits");
  reg1_gap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    regs[1][3:0] == 4'h0)
    else $error("register 1 low nibble set");
  reset_level_a: assert property (@(posedge SYS_CLK)
    $rose(RST_N) |-> (PRIO.timer_one_prio == 3'h4) && (regs[0] == 16'h4444))
    else $error("field not at level 4 after reset");
  write_lands_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (take && HWRITE && HADDR == OFFS_CTRL_0) ##1 1'b1 |=>
      (regs[0] == ($past(HWDATA[15:0]) & MASK_CTRL_0)))
    else $error("write to register 0 lost");
  prio_follow_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    seen_rst && $past(RST_N) |-> (PRIO.ext_irq_one_prio == $past(regs[5][2:0])))
    else $error("priority output does not follow register");
  off_disables_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $past(RST_N) && (regs[0][14:12] == 3'h0) |=> !SRC_ENABLED[NUM_SRC-1])
    else $error("disabled source still enabled");
  top_level_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $past(RST_N) && (regs[4][2:0] == 3'h7) |=> (PRIO.i2c_one_slave_prio == 3'h7) && SRC_ENABLED[1])
    else $error("level 7 not passed");
  low_level_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $past(RST_N) && (regs[2][2:0] == 3'h1) |=> (PRIO.timer_three_prio == 3'h1))
    else $error("level 1 not passed");
  reg0_gap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (regs[0] & ~MASK_CTRL_0) == 16'h0000)
    else $error("register 0 holds unimplemented bits");
  reg2_gap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (regs[2] & ~MASK_CTRL_2) == 16'h0000)
    else $error("register 2 holds unimplemented bits");
  reg4_gap_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (regs[4] & ~MASK_CTRL_4) == 16'h0000)
    else $error("register 4 holds unimplemented bits");
  unmapped_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    take && !HWRITE && !addr_hit |=> (HRDATA == 32'h0000_0000))
    else $error("unmapped read not zero");
  irq_one_en_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $past(RST_N) |-> (SRC_ENABLED[0] == ($past(regs[5][2:0]) != 3'h0)))
    else $error("ext irq one enable wrong");
  slave_en_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    $past(RST_N) |-> (SRC_ENABLED[1] == ($past(regs[4][2:0]) != 3'h0)))
    else $error("i2c slave enable wrong");
  write_reg3_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (take && HWRITE && HADDR == OFFS_CTRL_3) ##1 1'b1 |=>
      (regs[3] == ($past(HWDATA[15:0]) & MASK_CTRL_3)))
    else $error("write to register 3 lost");
  write_reg5_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (take && HWRITE && HADDR == OFFS_CTRL_5) ##1 1'b1 |=>
      (regs[5] == ($past(HWDATA[15:0]) & MASK_CTRL_5)))
    else $error("write to register 5 lost");

  wr_cov: cover property (@(posedge SYS_CLK) disable iff (!RST_N) wr_pend);
  rd_cov: cover property (@(posedge SYS_CLK) disable iff (!RST_N) take && !HWRITE && addr_hit);
  off_cov: cover property (@(posedge SYS_CLK) disable iff (!RST_N) !SRC_ENABLED[0]);
  unmap_cov: cover property (@(posedge SYS_CLK) disable iff (!RST_N) take && !addr_hit);
  top_cov: cover property (@(posedge SYS_CLK) disable iff (!RST_N) PRIO.timer_one_prio == 3'h7);
endmodule : interrupt_priority_regs_low
`default_nettype wire

/* File: bench/interrupt_priority_regs_low_bench.sv */
// bench: bus access and priority output checks for the low priority registers
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_regs_low_bench;
  import prio_regs_pkg::*;
  localparam logic [15:0] MASKS [NUM_REGS] = '{MASK_CTRL_0, MASK_CTRL_1, MASK_CTRL_2,
    MASK_CTRL_3, MASK_CTRL_4, MASK_CTRL_5};
  localparam logic [15:0] RESETS [NUM_REGS] = '{RESET_CTRL_0, RESET_CTRL_1, RESET_CTRL_2,
    RESET_CTRL_3, RESET_CTRL_4, RESET_CTRL_5};
  // patterns set every code 0..7 and also the unimplemented bits
  localparam logic [15:0] PATS [4] = '{16'hFFFF, 16'hF1A3, 16'h3E5C, 16'h0000};
  logic sys_clk;
  logic rst_n;
  logic hsel;
  logic hwrite;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout;
  logic hresp;
  wire logic hready;
  prio_bundle_t prio;
  logic [NUM_SRC-1:0] src_enabled;
  logic [NUM_SRC-1:0] en;
  logic [15:0] img [NUM_REGS];
  logic [15:0] rot;
  int fails = 0;
  int n_compared = 0;
  // single slave: its ready is the bus ready
  assign hready = hreadyout;
  interrupt_priority_regs_low i_interrupt_priority_regs_low (.SYS_CLK(sys_clk), .RST_N(rst_n),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .PRIO(prio), .SRC_ENABLED(src_enabled));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // address phase held until ready, then data phase held until ready
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic logic [53:0] exp_prio();
    exp_prio = {img[0][14:12], img[0][10:8], img[0][6:4], img[0][2:0],
      img[1][14:12], img[1][10:8], img[1][6:4],
      img[2][14:12], img[2][10:8], img[2][6:4], img[2][2:0], img[3][6:4], img[3][2:0],
      img[4][14:12], img[4][10:8], img[4][6:4], img[4][2:0], img[5][2:0]};
  endfunction : exp_prio
  // outputs trail the register by one edge
  task automatic check_out();
    @(posedge sys_clk);
    #1;
    for (int g = 0; g < NUM_SRC; g++) begin
      en[g] = |((exp_prio() >> (3 * g)) & 54'h7);
    end
    check("prio", prio, exp_prio());
    check("src_enabled", src_enabled, en);
    check("hresp", hresp, 1'b0);
    check("hreadyout", hreadyout, 1'b1);
  endtask : check_out
  task automatic read_all();
    for (int g = 0; g < NUM_REGS; g++) begin
      bus(1'b0, 12'(4 * g), 32'h0);
      check("register", rd, {16'h0, img[g]});
    end
  endtask : read_all
  task automatic reset_and_check();
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    img = RESETS;
    check_out();
    read_all();
  endtask : reset_and_check
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    reset_and_check();
    foreach (PATS[p]) begin
      for (int g = 0; g < NUM_REGS; g++) begin
        // rotate a nibble per register; register 4 gets the pattern unrotated like register 0, and register 5 gets zero
        rot = 16'((PATS[p] << (4 * g)) | (PATS[p] >> (16 - 4 * g)));
        bus(1'b1, 12'(4 * g), {16'hFFFF, rot});
        img[g] = rot & MASKS[g];
        check_out();
      end
      read_all();
    end
    // unmapped places ignore writes and read zero
    bus(1'b1, 12'h018, 32'hFFFF_FFFF);
    bus(1'b1, 12'h020, 32'hFFFF_FFFF);
    check_out();
    bus(1'b0, 12'h018, 32'h0);
    check("unmapped 018", rd, 32'h0);
    bus(1'b0, 12'h020, 32'h0);
    check("unmapped 020", rd, 32'h0);
    // second reset in mid-run after every field was cleared
    reset_and_check();
    results();
  end
  // run takes well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    fails++;
    results();
  end
endmodule : interrupt_priority_regs_low_bench
`default_nettype wire
